// ---- verilog/led_port_cfg.svh ----
// Constants of the serial host port: command codes, limits, field positions
`ifndef LED_PORT_CFG_SVH
`define LED_PORT_CFG_SVH

// ****************************************************************
// Command codes
// ****************************************************************
`define CMD_READ_STATUS 8'h70
`define CMD_READ_FRAME 8'h71
`define CMD_READ_LOOP 8'h72
`define CMD_READ_FLAGS 8'h73
`define CMD_READ_OPEN 8'h74
`define CMD_READ_SHORT 8'h75
`define CMD_RAM_WR_DISPLAY 8'h80
`define CMD_RAM_WR_FADE 8'h81
`define CMD_RAM_WR_ONOFF 8'h82
`define CMD_RAM_RD_DISPLAY 8'h88
`define CMD_RAM_RD_FADE 8'h89
`define CMD_RAM_RD_ONOFF 8'h8A

// ****************************************************************
// Address limits and pointer ranges
// ****************************************************************
`define LIMIT_BIN_DISPLAY 8'h08
`define LIMIT_GRAY_DISPLAY 8'h87
`define LIMIT_GRAY_FADE 8'h83
`define LIMIT_GRAY_ONOFF 8'h08
`define STATUS_BYTES 20
`define STATUS_LAST 8'h13
`define DETECT_COLS 9
`define DETECT_LAST 8'h09
`define DETECT_FIRST 8'h01
`define PTR_START 8'h00
`define DUMMY_BYTE 8'h00
`define INVALID_BYTE 8'h00

// ****************************************************************
// Bit counting and byte layout
// ****************************************************************
`define BIT_LAST 3'h7
`define BIT_FIRST 3'h0
`define PAD_BITS 2'h0
`define FLAG_PAD 6'h00
// Idle pin levels {data, clock, select}: clock and select idle high, so no false edge after reset
`define PIN_IDLE 3'h3

`endif

// ---- verilog/led_port_pkg.sv ----
// Types shared by the serial host port and its self-checking bench
package led_port_pkg;

  // ****************************************************************
  // RAM selection and transfer phases
  // ****************************************************************
  typedef enum logic [1:0] {RAM_DISPLAY, RAM_FADE, RAM_ONOFF} ram_sel_e;

  typedef enum {PH_IDLE, PH_CMD, PH_ADDR, PH_WDATA, PH_PARAM, PH_READ, PH_IGNORE} phase_e;

  // ****************************************************************
  // Status and RAM carriers
  // ****************************************************************
  typedef struct packed {
    logic [1:0] run_state;
    logic [3:0] index;
  } movie_state_s;

  typedef struct packed {
    ram_sel_e sel;
    logic [7:0] addr;
    logic [7:0] data;
  } ram_write_s;

endpackage

// ---- verilog/pin_sampler.sv ----
// Three-stage pin sampler with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module pin_sampler #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_LEVEL = '0
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [WIDTH-1:0] pins_in,
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] rise_out,
  output logic [WIDTH-1:0] fall_out
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

  // ****************************************************************
  // Filter: a change counts once stages two and three agree
  // ****************************************************************
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
    end
  end

  // First stage feeds only the second, to keep metastability contained
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s1_q <= RST_LEVEL;
      s2_q <= RST_LEVEL;
      s3_q <= RST_LEVEL;
      lvl_q <= RST_LEVEL;
    end else begin
      s1_q <= pins_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  // Edges are flagged in the cycle the filtered level moves
  assign level_out = lvl_d;
  assign rise_out = lvl_d & ~lvl_q;
  assign fall_out = ~lvl_d & lvl_q;
endmodule
`default_nettype wire

// ---- verilog/led_serial_port.sv ----
// Three-wire serial host port with status read-back for the LED matrix driver
//
// Notes on behaviour
// R1 - 71h returns run state and shown page
// R2 - 72h returns shown loop index, 1xxx endless
// R3 - Loop byte top bits give loop run state
// R4 - Undefined command data leaves functions unchanged
// R5 - 73h returns column-scan flag and overtemp flag
// R6 - Overtemp sets above 150C, clears below 125C
// R7 - Chip select low frames every transfer
// R8 - Data sampled on rising clock, MSB first
// R9 - Every eight bits load one byte
// R10 - Chip select fall restarts bit and byte counting
// R11 - Data pin drives after read command/address
// R12 - Chip select high releases pin, ends read
// R13 - Read data changes on falling clock edges
// R14 - Single access beyond limit is invalid
// R15 - Multi-byte pointer wraps to 00H past limit
// R16 - Limits: binary 08h; gray 87h/83h/08h
// R17 - Host reads only whole bytes
// R18 - Host samples between rising and falling edge
// R19 - Status pointer wraps after location 20
// R20 - Detection pointer wraps after ninth column
// R21 - 70h reads the internal status byte sequence
// R22 - 74h returns dummy then open column bytes
// R23 - 75h returns dummy then short column bytes
// R24 - Chip select high ignores clock and data
// R25 - First byte is command, rest parameters
`timescale 1ns/1ps
`default_nettype none
`include "led_port_cfg.svh"
module led_serial_port
  import led_port_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic chip_select_n_in,
  input wire logic serial_clk_in,
  input wire logic serial_data_io_in,
  output logic serial_data_io_out,
  output logic serial_data_io_oe_out,
  input wire logic gray_mode_in,
  input wire movie_state_s movie_frame_in,
  input wire movie_state_s movie_loop_in,
  input wire logic first_scan_column_in,
  input wire logic temp_above_150_in,
  input wire logic temp_below_125_in,
  input wire logic [`STATUS_BYTES-1:0][7:0] reg_status_in,
  input wire logic [`DETECT_COLS-1:0][7:0] open_detect_in,
  input wire logic [`DETECT_COLS-1:0][7:0] short_detect_in,
  output ram_write_s ram_write_out,
  output logic ram_write_en_out,
  output ram_sel_e ram_read_sel_out,
  output logic [7:0] ram_read_addr_out,
  input wire logic [7:0] ram_read_data_in,
  output logic [7:0] cmd_byte_out,
  output logic cmd_byte_first_out,
  output logic cmd_byte_valid_out,
  output logic overtemp_flag_out
);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic ram_supported(input ram_sel_e sel, input logic gray);
    ram_supported = gray || (sel == RAM_DISPLAY);
  endfunction

  function automatic logic [7:0] ram_limit(input ram_sel_e sel, input logic gray);
    ram_limit = `LIMIT_BIN_DISPLAY;
    if (gray) begin
      unique case (sel)
        RAM_FADE: ram_limit = `LIMIT_GRAY_FADE;
        RAM_ONOFF: ram_limit = `LIMIT_GRAY_ONOFF;
        default: ram_limit = `LIMIT_GRAY_DISPLAY;
      endcase
    end
  endfunction

  function automatic logic [7:0] wrap_ptr(input logic [7:0] ptr, input logic [7:0] last,
                                          input logic [7:0] first);
    wrap_ptr = (ptr >= last) ? first : ptr + 8'h01;
  endfunction

  function automatic logic [7:0] movie_byte(input movie_state_s st);
    movie_byte = {st.run_state, `PAD_BITS, st.index};
  endfunction

  // ****************************************************************
  // Pin sampling
  // ****************************************************************
  logic [2:0] pins_lvl, pins_rise, pins_fall;
  logic cs_n_lvl, cs_fall, sck_rise, sck_fall, sdi_lvl;

  pin_sampler #(.WIDTH(3), .RST_LEVEL(`PIN_IDLE)) u_pins (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .pins_in({serial_data_io_in, serial_clk_in, chip_select_n_in}),
    .level_out(pins_lvl),
    .rise_out(pins_rise),
    .fall_out(pins_fall)
  );

  assign cs_n_lvl = pins_lvl[0];
  assign cs_fall = pins_fall[0];
  assign sck_rise = pins_rise[1];
  assign sck_fall = pins_fall[1];
  assign sdi_lvl = pins_lvl[2];

  // ****************************************************************
  // Frame state
  // ****************************************************************
  phase_e phase_q, phase_d;
  logic [7:0] rx_shift_q, rx_shift_d, cmd_q, cmd_d, ptr_q, ptr_d;
  logic [7:0] tx_shift_q, tx_shift_d, cmd_out_q, cmd_out_d;
  logic [2:0] rx_cnt_q, rx_cnt_d, tx_cnt_q, tx_cnt_d;
  logic bad_q, bad_d, oe_q, oe_d, dout_q, dout_d, ovt_q, ovt_d, caf_q, caf_d;
  logic cmd_valid_q, cmd_valid_d, cmd_first_q, cmd_first_d;
  logic wr_en_q, wr_en_d;
  ram_write_s wr_q, wr_d;
  ram_sel_e sel_q, sel_d;
  logic is_ram_read_q, is_ram_read_d;
  logic byte_done;
  logic [7:0] rx_byte, rd_byte, rd_next;
  logic [3:0] col;

  assign rx_byte = {rx_shift_q[6:0], sdi_lvl};
  assign byte_done = sck_rise && (rx_cnt_q == `BIT_LAST);
  assign col = ptr_q[3:0] - 4'h1;

  // Byte to send at the pointer and the pointer after it
  always_comb begin
    rd_byte = `DUMMY_BYTE;
    rd_next = ptr_q;
    unique case (cmd_q)
      `CMD_READ_STATUS: begin
        rd_byte = reg_status_in[ptr_q[4:0]];
        rd_next = wrap_ptr(ptr_q, `STATUS_LAST, `PTR_START); // [R19] [R21]
      end
      `CMD_READ_FRAME: rd_byte = movie_byte(movie_frame_in); // [R1]
      `CMD_READ_LOOP: rd_byte = movie_byte(movie_loop_in); // [R2] [R3]
      `CMD_READ_FLAGS: rd_byte = {caf_q, `FLAG_PAD, ovt_q}; // [R5]
      `CMD_READ_OPEN, `CMD_READ_SHORT: begin
        if (ptr_q != `PTR_START) begin
          rd_byte = (cmd_q == `CMD_READ_OPEN) ? open_detect_in[col] : short_detect_in[col];
        end
        rd_next = wrap_ptr(ptr_q, `DETECT_LAST, `DETECT_FIRST); // [R20] [R22] [R23]
      end
      default: begin
        if (is_ram_read_q) begin
          rd_byte = bad_q ? `INVALID_BYTE : ram_read_data_in; // [R14]
          rd_next = wrap_ptr(ptr_q, ram_limit(sel_q, gray_mode_in), `PTR_START); // [R15]
        end
      end
    endcase
  end

  // Next-state logic of the whole frame
  always_comb begin
    phase_d = phase_q;
    rx_shift_d = rx_shift_q;
    rx_cnt_d = rx_cnt_q;
    cmd_d = cmd_q;
    ptr_d = ptr_q;
    bad_d = bad_q;
    oe_d = oe_q;
    dout_d = dout_q;
    tx_shift_d = tx_shift_q;
    tx_cnt_d = tx_cnt_q;
    sel_d = sel_q;
    is_ram_read_d = is_ram_read_q;
    cmd_out_d = cmd_out_q;
    cmd_first_d = cmd_first_q;
    cmd_valid_d = 1'b0;
    wr_en_d = 1'b0;
    wr_d = wr_q;
    if (cs_n_lvl) begin
      // Deselected: pin released, clock and data ignored [R12] [R24] [R7]
      phase_d = PH_IDLE;
      oe_d = 1'b0;
      rx_cnt_d = `BIT_FIRST;
      tx_cnt_d = `BIT_FIRST;
    end else if (cs_fall || phase_q == PH_IDLE) begin
      phase_d = PH_CMD; // [R10]
      rx_cnt_d = `BIT_FIRST;
      tx_cnt_d = `BIT_FIRST;
    end else if (phase_q == PH_READ) begin
      if (sck_fall) begin
        // New bit only on falling edges; a byte loads at its first bit [R13]
        if (tx_cnt_q == `BIT_FIRST) begin
          dout_d = rd_byte[7];
          tx_shift_d = {rd_byte[6:0], 1'b0};
          tx_cnt_d = `BIT_LAST;
          ptr_d = rd_next;
        end else begin
          dout_d = tx_shift_q[7];
          tx_shift_d = {tx_shift_q[6:0], 1'b0};
          tx_cnt_d = tx_cnt_q - 3'h1;
        end
      end
    end else if (sck_rise && phase_q != PH_IGNORE) begin
      rx_shift_d = rx_byte; // [R8]
      rx_cnt_d = rx_cnt_q + 3'h1;
      if (byte_done) begin
        unique case (phase_q)
          PH_CMD: begin
            // First byte of a frame is the command [R25] [R9]
            cmd_d = rx_byte;
            ptr_d = `PTR_START;
            is_ram_read_d = 1'b0;
            unique case (rx_byte)
              `CMD_READ_STATUS, `CMD_READ_FRAME, `CMD_READ_LOOP, `CMD_READ_FLAGS,
              `CMD_READ_OPEN, `CMD_READ_SHORT: begin
                phase_d = PH_READ; // [R11]
                oe_d = 1'b1;
              end
              `CMD_RAM_WR_DISPLAY, `CMD_RAM_WR_FADE, `CMD_RAM_WR_ONOFF,
              `CMD_RAM_RD_DISPLAY, `CMD_RAM_RD_FADE, `CMD_RAM_RD_ONOFF: begin
                sel_d = ram_sel_e'(rx_byte[1:0]);
                is_ram_read_d = rx_byte[3];
                // No fade or on/off memory in binary mode [R16] [R4]
                phase_d = ram_supported(ram_sel_e'(rx_byte[1:0]), gray_mode_in) ?
                          PH_ADDR : PH_IGNORE;
              end
              default: begin
                if (rx_byte < `CMD_READ_STATUS) begin
                  phase_d = PH_PARAM;
                  cmd_valid_d = 1'b1;
                  cmd_first_d = 1'b1;
                  cmd_out_d = rx_byte;
                end else begin
                  phase_d = PH_IGNORE; // [R4]
                end
              end
            endcase
          end
          PH_ADDR: begin
            ptr_d = rx_byte;
            bad_d = rx_byte > ram_limit(sel_q, gray_mode_in); // [R14] [R16]
            if (is_ram_read_q) begin
              phase_d = PH_READ; // [R11]
              oe_d = 1'b1;
            end else begin
              phase_d = PH_WDATA;
            end
          end
          PH_WDATA: begin
            if (!bad_q) begin
              wr_en_d = 1'b1;
              wr_d = '{sel: sel_q, addr: ptr_q, data: rx_byte};
              ptr_d = wrap_ptr(ptr_q, ram_limit(sel_q, gray_mode_in), `PTR_START); // [R15]
            end
          end
          default: begin
            cmd_valid_d = 1'b1;
            cmd_first_d = 1'b0;
            cmd_out_d = rx_byte;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      phase_q <= PH_IDLE;
      rx_shift_q <= 8'h00;
      rx_cnt_q <= `BIT_FIRST;
      cmd_q <= 8'h00;
      ptr_q <= `PTR_START;
      bad_q <= 1'b0;
      oe_q <= 1'b0;
      dout_q <= 1'b0;
      tx_shift_q <= 8'h00;
      tx_cnt_q <= `BIT_FIRST;
      sel_q <= RAM_DISPLAY;
      is_ram_read_q <= 1'b0;
      cmd_out_q <= 8'h00;
      cmd_first_q <= 1'b0;
      cmd_valid_q <= 1'b0;
      wr_en_q <= 1'b0;
      wr_q <= '{sel: RAM_DISPLAY, addr: 8'h00, data: 8'h00};
    end else begin
      phase_q <= phase_d;
      rx_shift_q <= rx_shift_d;
      rx_cnt_q <= rx_cnt_d;
      cmd_q <= cmd_d;
      ptr_q <= ptr_d;
      bad_q <= bad_d;
      oe_q <= oe_d;
      dout_q <= dout_d;
      tx_shift_q <= tx_shift_d;
      tx_cnt_q <= tx_cnt_d;
      sel_q <= sel_d;
      is_ram_read_q <= is_ram_read_d;
      cmd_out_q <= cmd_out_d;
      cmd_first_q <= cmd_first_d;
      cmd_valid_q <= cmd_valid_d;
      wr_en_q <= wr_en_d;
      wr_q <= wr_d;
    end
  end

  // ****************************************************************
  // Function flags
  // ****************************************************************

  // Hysteresis between the two comparators; the set wins a tie
  always_comb begin
    ovt_d = ovt_q;
    if (temp_above_150_in) begin
      ovt_d = 1'b1; // [R6]
    end else if (temp_below_125_in) begin
      ovt_d = 1'b0; // [R6]
    end
    caf_d = first_scan_column_in; // [R5]
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ovt_q <= 1'b0;
      caf_q <= 1'b0;
    end else begin
      ovt_q <= ovt_d;
      caf_q <= caf_d;
    end
  end

  // Outputs straight from flops
  assign serial_data_io_out = dout_q;
  assign serial_data_io_oe_out = oe_q;
  assign ram_write_out = wr_q;
  assign ram_write_en_out = wr_en_q;
  assign ram_read_sel_out = sel_q;
  assign ram_read_addr_out = ptr_q;
  assign cmd_byte_out = cmd_out_q;
  assign cmd_byte_first_out = cmd_first_q;
  assign cmd_byte_valid_out = cmd_valid_q;
  assign overtemp_flag_out = ovt_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence load_s(logic [7:0] code);
    phase_q == PH_READ && cmd_q == code && sck_fall && tx_cnt_q == `BIT_FIRST;
  endsequence

  sequence cmd_byte_s;
    !cs_n_lvl && phase_q == PH_CMD && byte_done;
  endsequence

  pin_release_idle_a: assert property (cs_n_lvl |=> !serial_data_io_oe_out) // [R12] [R24]
    else $error("data pin driven while deselected");
  frame_start_a: assert property (cs_fall && !cs_n_lvl
    |=> phase_q == PH_CMD && rx_cnt_q == `BIT_FIRST) // [R10]
    else $error("frame did not restart at select fall");
  command_capture_a: assert property (cmd_byte_s |=> cmd_q == $past(rx_byte)) // [R8] [R9] [R25]
    else $error("command byte not captured");
  status_read_drive_a: assert property (cmd_byte_s ##0 rx_byte == `CMD_READ_FRAME
    |=> serial_data_io_oe_out && phase_q == PH_READ) // [R11]
    else $error("data pin not driven for read");
  frame_byte_a: assert property (!cs_n_lvl ##0 load_s(`CMD_READ_FRAME)
    |=> serial_data_io_out == $past(movie_frame_in.run_state[1])
        && tx_shift_q[4:1] == $past(movie_frame_in.index)) // [R1]
    else $error("frame status byte wrong");
  loop_byte_a: assert property (!cs_n_lvl ##0 load_s(`CMD_READ_LOOP)
    |=> tx_shift_q[7] == $past(movie_loop_in.run_state[0])
        && tx_shift_q[4:1] == $past(movie_loop_in.index)) // [R2] [R3]
    else $error("loop status byte wrong");
  flag_byte_a: assert property (!cs_n_lvl ##0 load_s(`CMD_READ_FLAGS)
    |=> serial_data_io_out == $past(caf_q) && tx_shift_q[1] == $past(ovt_q)) // [R5]
    else $error("function flag byte wrong");
  read_edge_only_a: assert property (!sck_fall && !cs_n_lvl && phase_q == PH_READ
    |=> $stable(serial_data_io_out)) // [R13]
    else $error("read data moved off a falling edge");
  overtemp_hyst_a: assert property (temp_above_150_in |=> overtemp_flag_out ##1
    (overtemp_flag_out || $past(temp_below_125_in && !temp_above_150_in))) // [R6]
    else $error("overtemp flag hysteresis broken");
  status_wrap_a: assert property (!cs_n_lvl ##0 load_s(`CMD_READ_STATUS)
    ##0 ptr_q == `STATUS_LAST |=> ptr_q == `PTR_START) // [R19]
    else $error("status pointer did not wrap");
  detect_wrap_a: assert property (!cs_n_lvl ##0 load_s(`CMD_READ_OPEN)
    ##0 ptr_q == `DETECT_LAST |=> ptr_q == `DETECT_FIRST) // [R20] [R22]
    else $error("detection pointer did not wrap");
  bad_write_drop_a: assert property (!cs_n_lvl && phase_q == PH_WDATA && byte_done && bad_q
    |=> !ram_write_en_out) // [R14]
    else $error("write beyond limit accepted");
  ram_wrap_a: assert property (!cs_n_lvl && phase_q == PH_WDATA && byte_done && !bad_q
    && ptr_q == ram_limit(sel_q, gray_mode_in) |=> ptr_q == `PTR_START && ram_write_en_out) // [R15]
    else $error("RAM pointer did not wrap");

endmodule
`default_nettype wire

// ---- sim/serial_host_model.sv ----
// Host controller model that drives the three-wire serial port
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  input wire logic clk_in,
  input wire logic wire_level_in,
  output logic chip_select_n_out,
  output logic serial_clk_out,
  output logic data_out,
  output logic data_oe_out
);
  // Half of the 160 ns serial clock, in 8 ns cycles
  localparam int HALF = 10;

  // Idle bus: select high, clock standing high, data released
  initial begin
    chip_select_n_out = 1'b1;
    serial_clk_out = 1'b1;
    data_out = 1'b0;
    data_oe_out = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // Every frame opens with select falling
  task automatic open_frame();
    @(posedge clk_in);
    chip_select_n_out <= 1'b0;
    idle(HALF);
  endtask

  // Data changes with the falling clock and is held well past the rise,
  // since the device sees the pins several cycles late
  task automatic bit_cycle(input logic drive, input logic b, output logic got);
    @(posedge clk_in);
    serial_clk_out <= 1'b0;
    data_oe_out <= drive;
    data_out <= b;
    idle(HALF);
    serial_clk_out <= 1'b1;
    idle(1);
    got = wire_level_in;
    idle(3);
    data_oe_out <= 1'b0;
    idle(HALF - 5);
  endtask

  // MSB first; fewer than eight bits only where a test breaks a frame
  task automatic put_bits(input logic [7:0] b, input int n);
    logic g;
    for (int i = 7; i > 7 - n; i--) begin
      bit_cycle(1'b1, b[i], g);
    end
  endtask

  // Reads always take whole bytes
  task automatic get_byte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b0, 1'b0, b[i]);
    end
  endtask

  // The host ends each frame by raising select
  task automatic close_frame();
    @(posedge clk_in);
    data_oe_out <= 1'b0;
    chip_select_n_out <= 1'b1;
    idle(HALF);
  endtask
endmodule
`default_nettype wire

// ---- sim/led_serial_port_bench.sv ----
// Self-checking bench for the serial host port and its status read-back
`timescale 1ns/1ps
`default_nettype none
`include "led_port_cfg.svh"
`define CHECK(got, exp) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("MISMATCH at %0t got %h expected %h", $time, (got), (exp)); \
  end \
end
module led_serial_port_bench
  import led_port_pkg::*;
;
  // ********
  // Signals
  // ********
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic csn, sclk, hdata, hoe, dout, doe, wr_en, cmd_valid, cmd_first, overtemp;
  logic last_q = 1'b0;
  logic wire_lvl;
  logic gray_mode = 1'b1;
  movie_state_s mframe = '0;
  movie_state_s mloop = '0;
  logic first_col = 1'b0;
  logic above = 1'b0;
  logic below = 1'b0;
  logic [`STATUS_BYTES-1:0][7:0] stat;
  logic [`DETECT_COLS-1:0][7:0] opn, shrt;
  ram_write_s wr;
  ram_sel_e rd_sel;
  logic [7:0] rd_addr, rd_data, cmd_byte, b;
  logic [17:0] writes_seen[$], writes_exp[$];
  logic [8:0] cmds_seen[$];
  int mismatches = 0;
  int checks_done = 0;
  // Row: command, address, limit, {gray, valid}
  logic [31:0] ram_rows [10] = '{32'h8087_8711, 32'h8183_8311, 32'h8208_0811,
    32'h8008_0801, 32'h8100_0000, 32'h8009_0800, 32'h8887_8711, 32'h8984_8310,
    32'h8A08_0811, 32'h8808_0801};

  always #4 clk_in = ~clk_in;

  // Undriven wire shows a changing pattern so a stale value cannot pass
  always_comb wire_lvl = doe ? dout : (hoe ? hdata : ~last_q);
  always @(posedge clk_in) last_q <= wire_lvl;

  // RAM stand-in: data depends on both memory and address
  assign rd_data = rd_addr ^ {6'h00, rd_sel} ^ 8'h5A;

  // Collect write pulses and forwarded bytes
  always @(posedge clk_in) begin
    if (wr_en === 1'b1) writes_seen.push_back(wr);
    if (cmd_valid === 1'b1) cmds_seen.push_back({cmd_first, cmd_byte});
  end

  // Status and detection tables, fixed from time zero
  initial begin
    for (int i = 0; i < `STATUS_BYTES; i++) begin
      stat[i] = 8'h30 + 8'(i);
    end
    for (int i = 0; i < `DETECT_COLS; i++) begin
      opn[i] = 8'hA0 + 8'(i);
      shrt[i] = 8'hC0 + 8'(i);
    end
  end

  led_serial_port DUT (.clk_in(clk_in), .srst_in(srst_in), .chip_select_n_in(csn),
    .serial_clk_in(sclk), .serial_data_io_in(wire_lvl), .serial_data_io_out(dout),
    .serial_data_io_oe_out(doe), .gray_mode_in(gray_mode), .movie_frame_in(mframe),
    .movie_loop_in(mloop), .first_scan_column_in(first_col), .temp_above_150_in(above),
    .temp_below_125_in(below), .reg_status_in(stat), .open_detect_in(opn),
    .short_detect_in(shrt), .ram_write_out(wr), .ram_write_en_out(wr_en),
    .ram_read_sel_out(rd_sel), .ram_read_addr_out(rd_addr), .ram_read_data_in(rd_data),
    .cmd_byte_out(cmd_byte), .cmd_byte_first_out(cmd_first),
    .cmd_byte_valid_out(cmd_valid), .overtemp_flag_out(overtemp));

  serial_host_model HOST (.clk_in(clk_in), .wire_level_in(wire_lvl),
    .chip_select_n_out(csn), .serial_clk_out(sclk), .data_out(hdata),
    .data_oe_out(hoe));

  // ********
  // Tasks
  // ********
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic report_and_stop();
    if (mismatches == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic finish_frame();
    HOST.close_frame();
    `CHECK(doe, 1'b0)
  endtask

  // Read one status command twice; each byte is resampled
  task automatic status_read(input logic [7:0] cmd, input logic [7:0] exp);
    HOST.open_frame();
    HOST.put_bits(cmd, 8);
    `CHECK(doe, 1'b1)
    repeat (2) begin
      HOST.get_byte(b);
      `CHECK(b, exp)
    end
    finish_frame();
  endtask

  // Two data bytes from the given address; valid rows start at the limit
  task automatic ram_case(input logic [31:0] r);
    logic [7:0] a;
    logic [7:0] dv;
    a = r[23:16];
    dv = 8'h11;
    gray_mode <= r[4];
    writes_seen.delete();
    writes_exp.delete();
    HOST.open_frame();
    HOST.put_bits(r[31:24], 8);
    HOST.put_bits(a, 8);
    repeat (2) begin
      if (r[27]) begin
        HOST.get_byte(b);
        `CHECK(b, r[0] ? (a ^ {6'h00, r[25:24]} ^ 8'h5A) : `INVALID_BYTE)
      end else begin
        HOST.put_bits(dv, 8);
        if (r[0]) writes_exp.push_back({r[25:24], a, dv});
      end
      a = (a == r[15:8]) ? `PTR_START : a + 8'h01;
      dv = dv + 8'h11;
    end
    finish_frame();
    `CHECK(writes_seen.size(), writes_exp.size())
    for (int j = 0; j < writes_exp.size(); j++) begin
      `CHECK(writes_seen[j], writes_exp[j])
    end
  endtask

  // Cuts a hung run short
  initial begin
    #800000;
    mismatches++;
    report_and_stop();
  end

  // ********
  // Main sequence
  // ********
  initial begin
    tick(16);
    srst_in <= 1'b0;
    tick(4);
    `CHECK(overtemp, 1'b0)
    `CHECK(doe, 1'b0)
    status_read(`CMD_READ_FRAME, 8'h00);
    // A broken frame and clocking with select high must leave no trace
    HOST.open_frame();
    HOST.put_bits(8'hFF, 3);
    HOST.close_frame();
    HOST.put_bits(8'h31, 8);
    HOST.open_frame();
    HOST.put_bits(8'h31, 8);
    HOST.put_bits(8'h42, 8);
    finish_frame();
    HOST.open_frame();
    HOST.put_bits(8'h76, 8);
    HOST.put_bits(8'h55, 8);
    `CHECK(doe, 1'b0)
    finish_frame();
    `CHECK(cmds_seen.size(), 2)
    `CHECK(cmds_seen[0], 9'h131)
    `CHECK(cmds_seen[1], 9'h042)
    // Status bytes and flag hysteresis
    mframe <= '{2'b10, 4'hA};
    mloop <= '{2'b11, 4'h9};
    first_col <= 1'b1;
    above <= 1'b1;
    tick(2);
    above <= 1'b0;
    tick(8);
    `CHECK(overtemp, 1'b1)
    status_read(`CMD_READ_FRAME, 8'h8A);
    status_read(`CMD_READ_LOOP, 8'hC9);
    status_read(`CMD_READ_FLAGS, 8'h81);
    below <= 1'b1;
    first_col <= 1'b0;
    mloop <= '{2'b10, 4'h3};
    tick(2);
    `CHECK(overtemp, 1'b0)
    status_read(`CMD_READ_FLAGS, 8'h00);
    status_read(`CMD_READ_LOOP, 8'h83);
    // Both comparators at once: the set must win
    above <= 1'b1;
    tick(2);
    `CHECK(overtemp, 1'b1)
    above <= 1'b0;
    // Register status sequence wraps after twenty bytes
    HOST.open_frame();
    HOST.put_bits(`CMD_READ_STATUS, 8);
    for (int i = 0; i < 21; i++) begin
      HOST.get_byte(b);
      `CHECK(b, stat[i % 20])
    end
    finish_frame();
    // Open then short detection: dummy byte, nine columns, wrap
    for (int s = 0; s < 2; s++) begin
      HOST.open_frame();
      HOST.put_bits((s != 0) ? `CMD_READ_SHORT : `CMD_READ_OPEN, 8);
      HOST.get_byte(b);
      `CHECK(b, `DUMMY_BYTE)
      for (int i = 0; i < 10; i++) begin
        HOST.get_byte(b);
        `CHECK(b, (s != 0) ? shrt[i % 9] : opn[i % 9])
      end
      finish_frame();
    end
    // RAM writes at each limit and reads at each but the fade limit 83h, in both modes
    for (int k = 0; k < 10; k++) begin
      ram_case(ram_rows[k]);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
